// ---- spi_eeprom_pkg.sv ----
// constants, encodings and helpers for the serial eeprom front end
package spi_eeprom_pkg;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 8;
  localparam int PAGE_W     = 6;
  localparam int PAGE_NUM_W = ADDR_W - PAGE_W;
  localparam int MEM_WORDS  = 32768;
  localparam int PAGE_BYTES = 64;
  localparam logic [PAGE_W-1:0] PAGE_FIRST = 6'h00;
  localparam logic [PAGE_W-1:0] PAGE_LAST  = 6'h3f;
  localparam logic [PAGE_W-1:0] PAGE_STEP  = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_STEP  = 15'h0001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 15'h0000;
  // high address byte carries one unused bit on top
  localparam int ADDR_HI_W = ADDR_W - DATA_W;

  // ****************************************************************
  // serial framing
  // ****************************************************************
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_STEP  = 3'h1;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // ****************************************************************
  // instruction codes
  // ****************************************************************
  localparam logic [7:0] OPC_SET_LATCH    = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH    = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_MEM_READ     = 8'h03;
  localparam logic [7:0] OPC_MEM_WRITE    = 8'h02;

  // ****************************************************************
  // status byte layout
  // ****************************************************************
  localparam int ST_PEN_BIT   = 7;
  localparam int ST_LOCK_HI   = 4;
  localparam int ST_LOCK_LO   = 2;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_BUSY_BIT  = 0;
  localparam logic [1:0] ST_UNUSED     = 2'h0;
  localparam logic [7:0] ST_BUSY_VIEW  = 8'hff;
  localparam logic       ST_PEN_RESET  = 1'h0;
  localparam logic [2:0] ST_LOCK_RESET = 3'h0;

  // ****************************************************************
  // lock levels and protected ranges
  // ****************************************************************
  localparam logic [2:0] LOCK_NONE  = 3'h0;
  localparam logic [2:0] LOCK_Q4    = 3'h1;
  localparam logic [2:0] LOCK_HALF  = 3'h2;
  localparam logic [2:0] LOCK_ALL   = 3'h3;
  localparam logic [2:0] LOCK_P1    = 3'h4;
  localparam logic [2:0] LOCK_P2    = 3'h5;
  localparam logic [2:0] LOCK_P4    = 3'h6;
  localparam logic [2:0] LOCK_P8    = 3'h7;
  localparam logic [ADDR_W-1:0] LOCK_Q4_BASE   = 15'h6000;
  localparam logic [ADDR_W-1:0] LOCK_HALF_BASE = 15'h4000;
  localparam logic [ADDR_W-1:0] LOCK_P1_TOP    = 15'h003f;
  localparam logic [ADDR_W-1:0] LOCK_P2_TOP    = 15'h007f;
  localparam logic [ADDR_W-1:0] LOCK_P4_TOP    = 15'h00ff;
  localparam logic [ADDR_W-1:0] LOCK_P8_TOP    = 15'h01ff;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // state encodings
  // ****************************************************************
  typedef enum logic [4:0] {
    PH_OPCODE  = 5'b00001,
    PH_ADDR_HI = 5'b00010,
    PH_ADDR_LO = 5'b00100,
    PH_DATA    = 5'b01000,
    PH_IGNORE  = 5'b10000
  } phase_t;

  typedef enum logic [4:0] {
    CM_NONE      = 5'b00001,
    CM_LATCH_SET = 5'b00010,
    CM_LATCH_CLR = 5'b00100,
    CM_MEM_WR    = 5'b01000,
    CM_SR_WR     = 5'b10000
  } commit_t;

  // true when the address sits inside the locked region
  function automatic logic is_locked(input logic [2:0]        level,
                                     input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (level)
      LOCK_NONE: hit = 1'b0;
      LOCK_Q4:   hit = (addr >= LOCK_Q4_BASE);
      LOCK_HALF: hit = (addr >= LOCK_HALF_BASE);
      LOCK_ALL:  hit = 1'b1;
      LOCK_P1:   hit = (addr <= LOCK_P1_TOP);
      LOCK_P2:   hit = (addr <= LOCK_P2_TOP);
      LOCK_P4:   hit = (addr <= LOCK_P4_TOP);
      LOCK_P8:   hit = (addr <= LOCK_P8_TOP);
    endcase
    return hit;
  endfunction

endpackage

// ---- spi_eeprom_protect_interface.sv ----
// serial eeprom front end: decoder, write latch, status, lock protection
//
// How it works
// - chip select high deselects, floats serial out, resets sequence.
// - nothing is accepted until chip select has been seen falling.
// - input sampled on rising clock, output changes after falling clock.
// - pin low with pin enable set refuses status writes only.
// - pin falling while selected aborts pending status write.
// - pin enable clear ends pin refusal; a pin fall while selected still aborts a status write.
// - host pauses and resumes only while serial clock is low.
// - paused device ignores edges and resumes where it stopped.
// - opcode 06 sets the write latch, 04 clears it.
// - opcode 05 reads status, 01 writes status.
// - opcode 03 reads memory, 02 writes one to 64 bytes.
// - eight-bit instruction register, every byte most significant first.
// - first bit on first rising clock; clock may stop anywhere.
// - writes commit only with the write latch already set.
// - latch clear at reset and after every write cycle.
// - status: enable, two unused, lock level, latch, busy.
// - status readable at any time, even during a write.
// - busy is hardware only, one while writing.
// - status reads all ones while an internal write runs.
// - latch bit read-only; status write loads enable and lock.
// - lock level selects protected region refusing writes.
// - read takes sixteen address bits, uses fifteen, wraps at top.
// - page write address wraps inside the same page.
// - write starts only if select rises on a byte boundary.
// - status write ignores data bits 0, 1, 5 and 6.
`timescale 1ns/10ps
module spi_eeprom_protect_interface
  import spi_eeprom_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic wp_n,
  input  wire logic hold_n,
  output logic      so,
  output logic      so_oe
);

  localparam int TIMER_W = $clog2(WRITE_CYCLES_P + 1);
  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(WRITE_CYCLES_P - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;
  localparam logic [TIMER_W-1:0] TIMER_STEP = TIMER_W'(1);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [DATA_W-1:0] mem [MEM_WORDS];     // the array itself
  logic [DATA_W-1:0] page_buf [PAGE_BYTES];

  // ****************************************************************
  // link side (serial clock domain)
  // ****************************************************************
  logic                  sck_rst_n;
  phase_t                phase_q;
  logic [2:0]            bit_q;
  logic [DATA_W-1:0]     rx_q;
  logic [DATA_W-1:0]     rx_byte;
  logic [DATA_W-1:0]     opcode_q;
  logic [ADDR_W-1:0]     addr_q;
  logic                  byte_done;
  logic [PAGE_BYTES-1:0] mask_q;
  logic [PAGE_NUM_W-1:0] page_q;
  logic [DATA_W-1:0]     sr_data_q;
  commit_t               commit_q;
  logic [DATA_W-1:0]     stat_s1_q;
  logic [DATA_W-1:0]     stat_s2_q;
  logic [DATA_W-1:0]     sh_q;
  logic                  so_q;
  logic                  tx_load;
  logic [DATA_W-1:0]     tx_byte;

  // ****************************************************************
  // system side (clk domain)
  // ****************************************************************
  logic                  cs_s1_q, cs_s2_q, cs_s3_q;
  logic                  wp_s1_q, wp_s2_q, wp_s3_q;
  logic                  cs_rise, cs_fall, wp_fall;
  logic                  primed_q;
  logic                  abort_q;
  logic                  latch_q;
  logic                  busy_q;
  logic [TIMER_W-1:0]    timer_q;
  logic                  wr_active_q;
  logic [PAGE_W-1:0]     idx_q;
  logic                  pen_q;
  logic [2:0]            lock_q;
  logic                  pin_protect;
  logic                  accept;
  logic                  start_mem;
  logic                  start_sr;
  logic                  cycle_done;
  logic [DATA_W-1:0]     status_view;
  logic [ADDR_W-1:0]     wr_addr;

  function automatic phase_t phase_after(input logic [DATA_W-1:0] opc);
    phase_t p;
    p = PH_IGNORE;
    if (opc == OPC_MEM_READ || opc == OPC_MEM_WRITE) begin
      p = PH_ADDR_HI;
    end else if (opc == OPC_STATUS_READ || opc == OPC_STATUS_WRITE) begin
      p = PH_DATA;
    end
    return p;
  endfunction

  // what a select rise would commit right after this byte
  function automatic commit_t commit_after(input phase_t            ph,
                                           input logic [DATA_W-1:0] opc,
                                           input logic [DATA_W-1:0] rx);
    commit_t c;
    c = CM_NONE;
    if (ph == PH_OPCODE && rx == OPC_SET_LATCH) begin
      c = CM_LATCH_SET;
    end else if (ph == PH_OPCODE && rx == OPC_CLR_LATCH) begin
      c = CM_LATCH_CLR;
    end else if (ph == PH_DATA && opc == OPC_MEM_WRITE) begin
      c = CM_MEM_WR;
    end else if (ph == PH_DATA && opc == OPC_STATUS_WRITE) begin
      c = CM_SR_WR;
    end
    return c;
  endfunction

  assign sck_rst_n = rstn & ~cs_n;
  assign rx_byte   = {rx_q[DATA_W-2:0], si};
  assign byte_done = (bit_q == BIT_LAST);

  // ****************************************************************
  // instruction decode and framing
  // ****************************************************************
  // first rising edge after select takes bit 7
  always_ff @(posedge sck or negedge sck_rst_n) begin
    if (!sck_rst_n) begin
      phase_q  <= PH_OPCODE;
      bit_q    <= BIT_FIRST;
      rx_q     <= BYTE_ZERO;
      opcode_q <= BYTE_ZERO;
    end else if (hold_n) begin
      rx_q  <= rx_byte;
      bit_q <= bit_q + BIT_STEP;
      if (byte_done) begin
        unique case (phase_q)
          PH_OPCODE: begin
            opcode_q <= rx_byte;
            phase_q  <= phase_after(rx_byte);
          end
          PH_ADDR_HI: phase_q <= PH_ADDR_LO;
          PH_ADDR_LO: phase_q <= PH_DATA;
          PH_DATA:    phase_q <= PH_DATA;
          PH_IGNORE:  phase_q <= PH_IGNORE;
        endcase
      end
    end
  end

  // ****************************************************************
  // address counter
  // ****************************************************************
  always_ff @(posedge sck or negedge sck_rst_n) begin
    if (!sck_rst_n) begin
      addr_q <= ADDR_ZERO;
    end else if (hold_n && byte_done) begin
      if (phase_q == PH_ADDR_HI) begin
        addr_q[ADDR_W-1:DATA_W] <= rx_byte[ADDR_HI_W-1:0];
      end else if (phase_q == PH_ADDR_LO) begin
        addr_q[DATA_W-1:0] <= rx_byte;
      end else if (phase_q == PH_DATA && opcode_q == OPC_MEM_READ) begin
        addr_q <= addr_q + ADDR_STEP;
      end else if (phase_q == PH_DATA && opcode_q == OPC_MEM_WRITE) begin
        addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + PAGE_STEP;
      end
    end
  end

  // ****************************************************************
  // write capture, kept across deselect for the commit
  // ****************************************************************
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      mask_q    <= '0;
      page_q    <= '0;
      sr_data_q <= BYTE_ZERO;
    end else if (hold_n && byte_done) begin
      if (phase_q == PH_ADDR_LO) begin
        mask_q <= '0;
        page_q <= {addr_q[ADDR_W-1:DATA_W], rx_byte[DATA_W-1:PAGE_W]};
      end else if (phase_q == PH_DATA && opcode_q == OPC_MEM_WRITE) begin
        mask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
      end else if (phase_q == PH_DATA && opcode_q == OPC_STATUS_WRITE) begin
        sr_data_q <= rx_byte;
      end
    end
  end

  // page data bytes (no reset, guarded by the mask)
  always_ff @(posedge sck) begin
    if (hold_n && byte_done && phase_q == PH_DATA &&
        opcode_q == OPC_MEM_WRITE) begin
      page_buf[addr_q[PAGE_W-1:0]] <= rx_byte;
    end
  end

  // commit armed only on a byte boundary
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      commit_q <= CM_NONE;
    end else if (hold_n) begin
      commit_q <= byte_done ? commit_after(phase_q, opcode_q, rx_byte)
                            : CM_NONE;
    end
  end

  // status byte brought over to the link side
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      stat_s1_q <= BYTE_ZERO;
      stat_s2_q <= BYTE_ZERO;
    end else begin
      stat_s1_q <= status_view;
      stat_s2_q <= stat_s1_q;
    end
  end

  // ****************************************************************
  // serial output
  // ****************************************************************
  assign tx_load = (bit_q == BIT_FIRST) && (phase_q == PH_DATA) &&
                   (opcode_q == OPC_STATUS_READ ||
                    opcode_q == OPC_MEM_READ);
  // status read served at any time
  assign tx_byte = (opcode_q == OPC_STATUS_READ) ? stat_s2_q
                                                 : mem[addr_q];

  // output moves on the falling edge
  always_ff @(negedge sck or negedge rstn) begin
    if (!rstn) begin
      so_q <= 1'b0;
      sh_q <= BYTE_ZERO;
    end else if (hold_n) begin
      if (tx_load) begin
        so_q <= tx_byte[DATA_W-1];
        sh_q <= {tx_byte[DATA_W-2:0], 1'b0};
      end else begin
        so_q <= sh_q[DATA_W-1];
        sh_q <= {sh_q[DATA_W-2:0], 1'b0};
      end
    end
  end

  assign so    = so_q;
  assign so_oe = ~cs_n & hold_n;

  // ****************************************************************
  // pin synchronisers on the system clock
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
      wp_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      wp_s1_q <= wp_n;
      wp_s2_q <= wp_s1_q;
      wp_s3_q <= wp_s2_q;
    end
  end

  assign cs_rise = cs_s2_q & ~cs_s3_q;
  assign cs_fall = ~cs_s2_q & cs_s3_q;
  assign wp_fall = ~wp_s2_q & wp_s3_q;

  // wait for a first select fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      primed_q <= 1'b0;
    end else if (cs_fall) begin
      primed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      abort_q <= 1'b0;
    end else if (wp_fall && !cs_s2_q) begin
      abort_q <= 1'b1;
    end else if (cs_fall) begin
      abort_q <= 1'b0;
    end
  end

  // ****************************************************************
  // commit decisions
  // ****************************************************************
  // pin protect only with enable set
  assign pin_protect = pen_q & ~wp_s2_q;
  assign accept      = cs_rise & primed_q & ~busy_q;
  assign start_mem   = accept & latch_q & (commit_q == CM_MEM_WR);
  assign start_sr    = accept & latch_q & (commit_q == CM_SR_WR) &
                       ~abort_q & ~pin_protect;
  assign cycle_done  = busy_q & (timer_q == TIMER_LAST);

  // latch set, cleared, and dropped after a write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_q <= 1'b0;
    end else if (cycle_done) begin
      latch_q <= 1'b0;
    end else if (accept && commit_q == CM_LATCH_SET) begin
      latch_q <= 1'b1;
    end else if (accept && commit_q == CM_LATCH_CLR) begin
      latch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q  <= 1'b0;
      timer_q <= TIMER_ZERO;
    end else if (start_mem || start_sr) begin
      busy_q  <= 1'b1;
      timer_q <= TIMER_ZERO;
    end else if (busy_q) begin
      timer_q <= timer_q + TIMER_STEP;
      if (cycle_done) begin
        busy_q <= 1'b0;
      end
    end
  end

  // walk the page buffer once per memory write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_active_q <= 1'b0;
      idx_q       <= PAGE_FIRST;
    end else if (start_mem) begin
      wr_active_q <= 1'b1;
      idx_q       <= PAGE_FIRST;
    end else if (wr_active_q) begin
      idx_q <= idx_q + PAGE_STEP;
      if (idx_q == PAGE_LAST) begin
        wr_active_q <= 1'b0;
      end
    end
  end

  assign wr_addr = {page_q, idx_q};

  always_ff @(posedge clk) begin
    if (wr_active_q && mask_q[idx_q] && !is_locked(lock_q, wr_addr)) begin
      mem[wr_addr] <= page_buf[idx_q];
    end
  end

  // status write loads enable and lock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pen_q  <= ST_PEN_RESET;
      lock_q <= ST_LOCK_RESET;
    end else if (start_sr) begin
      // bits 0, 1, 5, 6 dropped
      pen_q  <= sr_data_q[ST_PEN_BIT];
      lock_q <= sr_data_q[ST_LOCK_HI:ST_LOCK_LO];
    end
  end

  assign status_view = busy_q ? ST_BUSY_VIEW
                              : {pen_q, ST_UNUSED, lock_q, latch_q, busy_q};

endmodule

// ---- spi_eeprom_protect_interface_checker.sv ----
// port assertions for the serial eeprom front end
`timescale 1ns/10ps
module spi_eeprom_protect_interface_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  logic so_pause_q;
  // output bit held from before a pause
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      so_pause_q <= 1'b0;
    end else if (hold_n) begin
      so_pause_q <= so;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_desel; cs_n |-> !so_oe; endproperty
  a_desel: assert property (p_desel)
    else $error("so driven while deselected");
  property p_sel; ($fell(cs_n) && hold_n) |-> so_oe; endproperty
  a_sel: assert property (p_sel)
    else $error("so not driven after select");
  property p_rel; $rose(cs_n) |-> (!so_oe)[*4]; endproperty
  a_rel: assert property (p_rel)
    else $error("so driven after deselect");
  property p_pz; (!cs_n && $fell(hold_n)) |-> (!so_oe)[*3]; endproperty
  a_pz: assert property (p_pz)
    else $error("so driven while paused");
  property p_res;
    (!cs_n && $rose(hold_n)) |-> so_oe && so == so_pause_q;
  endproperty
  a_res: assert property (p_res)
    else $error("so lost its bit across a pause");
  property p_pst; (!cs_n && !hold_n)[*2] |-> $stable(so); endproperty
  a_pst: assert property (p_pst)
    else $error("so changed while paused");
  // output changes only at a falling clock
  property p_fall;
    (!cs_n && $past(!cs_n) && !$stable(so)) |-> $fell(sck);
  endproperty
  a_fall: assert property (p_fall)
    else $error("so changed without falling clock");
  // rising clock never moves the output
  property p_rise; ($rose(sck) && !cs_n && $past(!cs_n)) |-> $stable(so);
  endproperty
  a_rise: assert property (p_rise)
    else $error("so changed on rising clock");
  c_pause: cover property (!cs_n && $fell(hold_n));
  c_frame: cover property ($rose(cs_n));
  c_one: cover property (so_oe && so);
endmodule
bind spi_eeprom_protect_interface spi_eeprom_protect_interface_checker
  spi_eeprom_protect_interface_checker_inst (.clk(clk), .rstn(rstn),
  .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .hold_n(hold_n),
  .so(so), .so_oe(so_oe));

// ---- spi_host_model.sv ----
// host serial master model for the eeprom front end
`timescale 1ns/10ps
module spi_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so,
  input  wire logic so_oe
);
  logic so_last;
  logic so_line;
  int   pause_bit;
  // idle levels, clock parked low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    so_last = 1'b0;
    pause_bit = -1;
  end
  // released line shows inverse of last bit
  always @(so or so_oe) begin
    if (so_oe) so_last = so;
  end
  assign so_line = so_oe ? so : ~so_last;
  // every frame opens with a falling select
  task automatic start();
    cs_n <= 1'b0;
    #43;  // keeps link edges off the system clock grid
  endtask
  // rise right after the last bit
  task automatic stop();
    #20 cs_n <= 1'b1;
    si <= ~si;
    #200;
  endtask
  // pause and resume only with clock low
  task automatic pause();
    hold_n <= 1'b0;
    #20;
    repeat (3) begin
      si <= ~si;
      #20 sck <= 1'b1;
      #20 sck <= 1'b0;
    end
    #20 hold_n <= 1'b1;
    #20;
  endtask
  task automatic xb(input logic [7:0] tx, input int nb,
                    output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      if (i == pause_bit) pause();
      si <= tx[i];
      #20 sck <= 1'b1;
      rx[i] = so_line;
      #40 sck <= 1'b0;
      #20;
    end
  endtask
endmodule

// ---- spi_eeprom_protect_interface_tb_top.sv ----
// self-checking bench for the serial eeprom front end
`timescale 1ns/10ps
module spi_eeprom_protect_interface_tb_top
  import spi_eeprom_pkg::*;
;
  logic clk, rstn, wp_n, sck, cs_n, si, hold_n, so, so_oe;
  logic [7:0] v;
  int         failures;
  int         compares;
  // device with a short write cycle
  spi_eeprom_protect_interface #(.WRITE_CYCLES_P(600))
    spi_eeprom_protect_interface_inst (.clk(clk), .rstn(rstn), .sck(sck),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .hold_n(hold_n), .so(so),
    .so_oe(so_oe));
  spi_host_model spi_host_model_inst (.sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .so(so), .so_oe(so_oe));
  // 200 mhz clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic t(input logic [7:0] b, input int nb = 8);
    logic [7:0] d;
    spi_host_model_inst.xb(b, nb, d);
  endtask
  task automatic sel(input bit on);
    if (on) spi_host_model_inst.start();
    else spi_host_model_inst.stop();
  endtask
  task automatic cmd(input logic [7:0] op);
    sel(1);
    t(op);
    sel(0);
  endtask
  task automatic sr_rd();
    sel(1);
    t(OPC_STATUS_READ);
    spi_host_model_inst.xb(BYTE_ZERO, 8, v);
    sel(0);
  endtask
  // poll status until the write cycle ends
  task automatic wait_done(input bit busy);
    sr_rd();
    if (busy) chk("busy view", ST_BUSY_VIEW, v);
    for (int i = 0; i < 20 && v === ST_BUSY_VIEW; i++) sr_rd();
    if (v === ST_BUSY_VIEW) begin
      failures++;
      $display("mismatch write end expected not ff seen %h", v);
    end
  endtask
  task automatic sr_wr(input logic [7:0] d, input bit drop);
    cmd(OPC_SET_LATCH);
    sel(1);
    t(OPC_STATUS_WRITE);
    if (drop) @(posedge clk) wp_n <= 1'b0;
    t(d);
    if (drop) @(posedge clk) wp_n <= 1'b1;
    sel(0);
  endtask
  task automatic mwr(input logic [15:0] a, input logic [23:0] d,
                     input int n, input int last, input bit latch);
    if (latch) cmd(OPC_SET_LATCH);
    sel(1);
    t(OPC_MEM_WRITE);
    t(a[15:8]);
    t(a[7:0]);
    for (int i = 0; i < n; i++) t(d[23-8*i -: 8], i == n - 1 ? last : 8);
    sel(0);
  endtask
  task automatic mrd(input logic [15:0] a, input logic [15:0] e,
                     input int nb);
    logic [7:0] r;
    sel(1);
    t(OPC_MEM_READ);
    t(a[15:8]);
    t(a[7:0]);
    for (int i = 0; i < nb; i++) begin
      spi_host_model_inst.xb(BYTE_ZERO, 8, r);
      chk("read data", e[15-8*i -: 8], r);
    end
    sel(0);
  endtask
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #450000;
    failures++;
    end_of_test();
  end
  // main sequence
  initial begin
    failures = 0;
    compares = 0;
    rstn = 1'b0;
    wp_n = 1'b1;
    v = 8'h00;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    sr_rd();
    chk("reset status", 8'h00, v);
    cmd(OPC_SET_LATCH);
    sr_rd();
    chk("latch set", 8'h02, v);
    cmd(OPC_CLR_LATCH);
    sr_rd();
    chk("latch clear", 8'h00, v);
    $display("test latch done");
    mwr(16'h0000, 24'ha5_0000, 1, 8, 1);
    cmd(OPC_SET_LATCH);
    wait_done(1);
    chk("latch after write", 8'h00, v);
    mwr(16'hfffe, 24'h11_2233, 3, 8, 1);
    wait_done(1);
    mrd(16'h7fff, 16'h22a5, 2);
    spi_host_model_inst.pause_bit = 3;
    mrd(16'h7ffe, 16'h1122, 2);
    spi_host_model_inst.pause_bit = -1;
    mwr(16'h0000, 24'h3c_0000, 1, 8, 0);
    mwr(16'h7fc0, 24'h99_0000, 1, 4, 1);
    wait_done(0);
    chk("cut write", 8'h02, v);
    cmd(OPC_CLR_LATCH);
    mrd(16'h7fc0, 16'h3300, 1);
    mrd(16'h0000, 16'ha500, 1);
    $display("test memory done");
    sr_wr(8'hff, 0);
    wait_done(1);
    chk("status write", 8'h9c, v);
    mwr(16'h0000, 24'h5a_0000, 1, 8, 1);
    wait_done(0);
    cmd(OPC_CLR_LATCH);
    mrd(16'h0000, 16'ha500, 1);
    sr_wr(8'h00, 1);
    wait_done(0);
    chk("pin abort", 8'h9e, v);
    @(posedge clk) wp_n <= 1'b0;
    sr_wr(8'h00, 0);
    wait_done(0);
    chk("pin refusal", 8'h9e, v);
    cmd(OPC_CLR_LATCH);
    @(posedge clk) wp_n <= 1'b1;
    sr_wr(8'h00, 0);
    wait_done(1);
    chk("unlock", 8'h00, v);
    @(posedge clk) wp_n <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      sr_wr({3'h0, c[2:0], 2'h0}, 0);
      wait_done(1);
      chk("lock code", {3'h0, c[2:0], 2'h0}, v);
    end
    @(posedge clk) wp_n <= 1'b1;
    $display("test status done");
    end_of_test();
  end
endmodule
